// File: sdmc_ctrl.sv
// Purpose: Sleep entry and exit sequencer with display mode flags
// Assumes: i_cmd_valid is a one-cycle strobe with a decoded i_cmd code
// Notes: Phase lengths are parameters so simulation can shorten them
`timescale 1ns/1ns
module sdmc_ctrl #(
  parameter int SLEEP_CYC = sdmc_pkg::SLEEP_CYC,   // Sleep entry time
  parameter int SETTLE_CYC = sdmc_pkg::SETTLE_CYC, // Reload window
  parameter int PHASE_CYC = 16,                    // Each power-up step
  parameter int FRAME_CYC = 1024                   // One panel frame
) (
  input wire logic i_clk,                       // 100 MHz clock
  input wire logic i_rst_b,                     // Sync hardware reset
  input wire logic i_cmd_valid,                 // Command strobe
  input wire logic [7:0] i_cmd,                 // Command code
  input wire logic i_idle_mode,                 // Idle mode is on
  output sdmc_pkg::sdmc_ctrl_s o_ctrl,          // Power controls
  output logic o_asleep,                        // Sleep reached
  output logic o_awake,                         // Fully awake
  output logic o_all_black,                     // Image mode status bit
  output logic o_normal,                        // Normal mode status
  output logic o_show_memory                    // Panel shows memory
);

  // State register and its next value
  sdmc_pkg::sdmc_regs_s r_q;
  sdmc_pkg::sdmc_regs_s r_d;
  logic show_q;
  logic show_d;

  // Decode helper
  function automatic logic is_cmd(input logic [7:0] c);
    is_cmd = i_cmd_valid && (i_cmd == c);
  endfunction : is_cmd

  // Default values after any reset
  function automatic sdmc_pkg::sdmc_regs_s reset_val();
    sdmc_pkg::sdmc_regs_s v;
    v = '0;
    v.state = sdmc_pkg::SDMC_ASLEEP;
    v.normal = 1'b1;
    v.asleep = 1'b1;
    return v;
  endfunction : reset_val

  // Next state logic
  always_comb begin
    r_d = r_q;
    r_d.ctrl.load_defaults = 1'b0;
    if (r_q.cnt != 32'h0) begin
      r_d.cnt = r_q.cnt - 32'h1;
    end
    if (r_q.wake_cnt != 32'h0) begin
      r_d.wake_cnt = r_q.wake_cnt - 32'h1;
    end
    // Self diagnostics while the reload window runs
    r_d.ctrl.self_diag = (r_q.wake_cnt > 32'h1);
    case (r_q.state)
      sdmc_pkg::SDMC_ASLEEP: begin
        // Only exit sleep wakes; enter sleep ignored
        if (is_cmd(sdmc_pkg::CMD_EXIT_SLEEP)) begin
          r_d.state = sdmc_pkg::SDMC_OSC_UP;
          r_d.asleep = 1'b0;
          r_d.ctrl.osc_en = 1'b1;
          r_d.ctrl.load_defaults = 1'b1;
          r_d.wake_cnt = 32'(SETTLE_CYC);
          r_d.cnt = 32'(PHASE_CYC);
        end
      end
      sdmc_pkg::SDMC_OSC_UP: begin
        if (r_q.cnt == 32'h0) begin
          r_d.ctrl.dcdc_en = 1'b1;
          r_d.state = sdmc_pkg::SDMC_DCDC_UP;
          r_d.cnt = 32'(PHASE_CYC);
        end
      end
      sdmc_pkg::SDMC_DCDC_UP: begin
        if (r_q.cnt == 32'h0) begin
          r_d.ctrl.offset_chg = 1'b1;
          r_d.state = sdmc_pkg::SDMC_OFFSET;
          r_d.cnt = 32'(PHASE_CYC);
        end
      end
      sdmc_pkg::SDMC_OFFSET: begin
        if (r_q.cnt == 32'h0) begin
          r_d.ctrl.offset_chg = 1'b0;
          r_d.ctrl.scan_en = 1'b1;
          r_d.ctrl.blank = 1'b1;
          r_d.frames = 4'(sdmc_pkg::BLANK_FRAMES);
          r_d.state = sdmc_pkg::SDMC_BLANK;
          r_d.cnt = 32'(FRAME_CYC);
        end
      end
      sdmc_pkg::SDMC_BLANK: begin
        // Blank frames regardless of display output switch
        if (r_q.cnt == 32'h0) begin
          if (r_q.frames == 4'h1) begin
            r_d.ctrl.blank = 1'b0;
            r_d.ctrl.backlight_en = 1'b1;
            r_d.ctrl.ambient_en = 1'b1;
            r_d.ctrl.dimming_en = 1'b1;
            r_d.awake = 1'b1;
            r_d.state = sdmc_pkg::SDMC_AWAKE;
          end else begin
            r_d.frames = r_q.frames - 4'h1;
            r_d.cnt = 32'(FRAME_CYC);
          end
        end
      end
      sdmc_pkg::SDMC_AWAKE: begin
        // Exit sleep while awake changes nothing
        if (is_cmd(sdmc_pkg::CMD_ENTER_SLEEP)) begin
          r_d.state = sdmc_pkg::SDMC_GOING_DOWN;
          r_d.awake = 1'b0;
          // Output off at once, no dimming on the way down
          r_d.ctrl.backlight_en = 1'b0;
          r_d.ctrl.ambient_en = 1'b0;
          r_d.ctrl.dimming_en = 1'b0;
          r_d.ctrl.blank = 1'b1;
          // Count so sleep is reached SLEEP_CYC edges after the command
          r_d.cnt = 32'(SLEEP_CYC - 2);
        end
      end
      sdmc_pkg::SDMC_GOING_DOWN: begin
        if (r_q.cnt == 32'h0) begin
          // Stop converter, oscillator and scanning
          r_d.ctrl = '0;
          r_d.asleep = 1'b1;
          r_d.state = sdmc_pkg::SDMC_ASLEEP;
        end
      end
      default: begin
        r_d = reset_val();
      end
    endcase
    // Display mode flags, kept in sleep too; memory untouched
    if (is_cmd(sdmc_pkg::CMD_NORMAL)) begin
      r_d.normal = 1'b1;
      r_d.all_black = 1'b0;
      r_d.all_on = 1'b0;
    end else if (is_cmd(sdmc_pkg::CMD_ALL_BLACK) && r_q.awake) begin
      r_d.all_black = 1'b1;
      r_d.all_on = 1'b0;
      r_d.normal = 1'b0;
    end else if (is_cmd(sdmc_pkg::CMD_ALL_ON)) begin
      r_d.all_black = 1'b0;
      r_d.all_on = 1'b1;
      r_d.normal = 1'b0;
    end
    // Software reset returns to defaults
    if (is_cmd(sdmc_pkg::CMD_SW_RESET)) begin
      r_d = reset_val();
    end
    // Memory shown when awake, unblanked and in normal mode
    show_d = r_d.awake && !r_d.ctrl.blank && !r_d.all_black
             && !r_d.all_on && (r_d.normal || !i_idle_mode);
  end

  // State register, hardware reset gives defaults
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      r_q <= reset_val();
      show_q <= 1'b0;
    end else begin
      r_q <= r_d;
      show_q <= show_d;
    end
  end

  // Outputs straight from flip-flops
  assign o_ctrl = r_q.ctrl;
  assign o_asleep = r_q.asleep;
  assign o_awake = r_q.awake;
  assign o_all_black = r_q.all_black;
  assign o_normal = r_q.normal;
  assign o_show_memory = show_q;

  // Enter sleep while asleep leaves state alone
  ignore_sleep_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (r_q.state == sdmc_pkg::SDMC_ASLEEP && is_cmd(sdmc_pkg::CMD_ENTER_SLEEP))
    |=> o_asleep) else $error("enter sleep left sleep");
  // Exit sleep starts oscillator next cycle
  wake_osc_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (o_asleep && is_cmd(sdmc_pkg::CMD_EXIT_SLEEP))
    |=> o_ctrl.osc_en && o_ctrl.load_defaults)
    else $error("wake did not start oscillator");
  // Oscillator before converter
  order_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_ctrl.dcdc_en |-> o_ctrl.osc_en) else $error("converter first");
  // Asleep means all supplies off
  sleep_off_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (o_asleep && r_q.state == sdmc_pkg::SDMC_ASLEEP) |-> !o_ctrl.osc_en
    && !o_ctrl.dcdc_en && !o_ctrl.scan_en) else $error("asleep but on");
  // Backlight off outside awake
  light_off_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !o_awake |-> !o_ctrl.backlight_en && !o_ctrl.dimming_en)
    else $error("backlight on while not awake");
  // All black only while awake accepted
  black_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $rose(o_all_black) |-> $past(o_awake)) else $error("black asleep");
  // Normal clears all black
  normal_clr_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    is_cmd(sdmc_pkg::CMD_NORMAL) && !is_cmd(sdmc_pkg::CMD_SW_RESET)
    |=> o_normal && !o_all_black) else $error("normal not restored");
  // Software reset gives defaults
  swrst_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    is_cmd(sdmc_pkg::CMD_SW_RESET) |=> o_asleep && o_normal && !o_all_black)
    else $error("soft reset defaults wrong");
  // Awake only leaves on enter sleep or reset
  stay_awake_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_awake && !is_cmd(sdmc_pkg::CMD_ENTER_SLEEP)
    && !is_cmd(sdmc_pkg::CMD_SW_RESET) |=> o_awake)
    else $error("left awake without cause");
  // Reload strobe lasts one cycle
  load_pulse_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    o_ctrl.load_defaults |=> !o_ctrl.load_defaults)
    else $error("reload strobe too long");
  // Diagnostics follow the reload
  diag_start_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    o_ctrl.load_defaults |=> o_ctrl.self_diag)
    else $error("diagnostics did not start");
  // Sleep entry counter stays inside the allowed time
  down_time_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    r_q.state == sdmc_pkg::SDMC_GOING_DOWN |-> r_q.cnt < 32'(SLEEP_CYC))
    else $error("sleep entry too long");
  // Scanning only with the converter up
  scan_dcdc_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    o_ctrl.scan_en |-> o_ctrl.dcdc_en)
    else $error("scanning without converter");
  // Offset charge after converter, before scanning
  offset_step_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    o_ctrl.offset_chg |-> o_ctrl.dcdc_en && !o_ctrl.scan_en)
    else $error("offset charge out of order");
  // Blank frames are scanned but not yet awake
  blank_frames_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    r_q.state == sdmc_pkg::SDMC_BLANK |-> o_ctrl.blank && o_ctrl.scan_en
    && !o_awake) else $error("blank frames wrong");
  // Awake means everything running and unblanked
  awake_on_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    o_awake |-> o_ctrl.osc_en && o_ctrl.dcdc_en && o_ctrl.scan_en
    && !o_ctrl.blank) else $error("awake but not running");
  // All black leaves power state alone
  black_power_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    o_awake && is_cmd(sdmc_pkg::CMD_ALL_BLACK) |=> $stable(o_ctrl.osc_en)
    && $stable(o_ctrl.scan_en) && $stable(o_awake)) else $error("black moved power");
  // All black held until all-on, normal or reset
  black_hold_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    o_all_black && !is_cmd(sdmc_pkg::CMD_NORMAL) && !is_cmd(sdmc_pkg::CMD_ALL_ON)
    && !is_cmd(sdmc_pkg::CMD_SW_RESET) |=> o_all_black) else $error("black lost");
  // All black refused while not awake
  black_refuse_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    !o_awake && is_cmd(sdmc_pkg::CMD_ALL_BLACK) |=> $stable(o_all_black))
    else $error("black taken while not awake");
  // Commands still taken while asleep
  sleep_cmd_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    o_asleep && is_cmd(sdmc_pkg::CMD_NORMAL) |=> o_normal && o_asleep)
    else $error("command lost in sleep");
  // Only exit sleep leaves sleep
  stay_asleep_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    o_asleep && !is_cmd(sdmc_pkg::CMD_EXIT_SLEEP) |=> o_asleep)
    else $error("left sleep without wake");
  // Wake while awake changes nothing
  wake_noop_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    o_awake && is_cmd(sdmc_pkg::CMD_EXIT_SLEEP) |=> o_awake
    && $stable(o_ctrl.blank) && !o_ctrl.load_defaults) else $error("wake redone");
  // Going down turns lights off at once, no dimming
  dark_down_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    o_awake && is_cmd(sdmc_pkg::CMD_ENTER_SLEEP) |=> !o_ctrl.backlight_en
    && !o_ctrl.ambient_en && !o_ctrl.dimming_en) else $error("lights stayed on");
  // All black hides memory
  show_black_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    o_all_black |-> !o_show_memory)
    else $error("memory shown in black mode");
  // Memory shown only when awake and unblanked
  show_awake_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    o_show_memory |-> o_awake && !o_ctrl.blank)
    else $error("memory shown while not awake");
  // Normal mode while awake shows memory, idle or not
  show_normal_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    o_awake && o_normal && !o_all_black |-> o_show_memory)
    else $error("memory hidden in normal mode");
  // Asleep means light control and backlight off
  asleep_dark_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    o_asleep |-> !o_awake && !o_ctrl.backlight_en && !o_ctrl.ambient_en)
    else $error("asleep but lit");

endmodule : sdmc_ctrl

// File: sdmc_ctrl_bench.sv
// Purpose: Self-checking bench for the sleep and mode controller
// Assumes: Shortened counts keep the run brief
// Notes: Outputs are sampled on the falling edge
`timescale 1ns/1ns
module sdmc_ctrl_bench;
  localparam int SLP = 200; // Shortened sleep entry time
  localparam int FRM = 8;   // Shortened frame
  logic i_clk = 1'b0;       // Clock
  logic i_rst_b = 1'b0;     // Reset, held at start
  logic i_idle_mode = 1'b0; // Idle mode level
  logic i_cmd_valid;        // Strobe from host
  logic [7:0] i_cmd;        // Code from host
  sdmc_pkg::sdmc_ctrl_s o_ctrl; // Power controls
  sdmc_pkg::sdmc_ctrl_s snap;   // Saved controls
  logic o_asleep;
  logic o_awake;
  logic o_all_black;
  logic o_normal;
  logic o_show_memory;
  int n_errors = 0;  // Mismatches
  int cmp_count = 0; // Comparisons
  // Clock of 10 ns
  always #5 i_clk = ~i_clk;
  sdmc_ctrl #(.SLEEP_CYC(SLP), .SETTLE_CYC(40), .PHASE_CYC(4),
    .FRAME_CYC(FRM)) sdmc_ctrl_inst (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_idle_mode(i_idle_mode),
    .o_ctrl(o_ctrl), .o_asleep(o_asleep), .o_awake(o_awake),
    .o_all_black(o_all_black), .o_normal(o_normal),
    .o_show_memory(o_show_memory));
  sdmc_host #(.GAP_CYC(SLP)) sdmc_host_inst (.i_clk(i_clk),
    .o_cmd_valid(i_cmd_valid), .o_cmd(i_cmd));
  // Count and report one comparison
  task automatic check(input bit ok, input string msg);
    cmp_count++;
    if (!ok) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : check
  // Send through the host model
  task automatic tx(input logic [7:0] code);
    sdmc_host_inst.send(code);
  endtask : tx
  // Defaults, and commands that must not wake
  task automatic t_reset;
    check(o_asleep === 1'b1 && o_normal === 1'b1, "reset modes");
    check(o_all_black === 1'b0 && o_ctrl === '0, "reset off");
    tx(sdmc_pkg::CMD_ALL_BLACK);
    tx(sdmc_pkg::CMD_NORMAL);
    check(o_asleep === 1'b1 && o_all_black === 1'b0, "no wake");
    $display("test reset done");
  endtask : t_reset
  // Wake sequence order and timing
  task automatic t_wake;
    int t_dc = 0;
    int t_off = 0;
    int t_scan = 0;
    int n_blank = 0;
    int n = 0;
    bit ld = 1'b0;
    bit sd = 1'b0;
    tx(sdmc_pkg::CMD_EXIT_SLEEP);
    check(o_ctrl.osc_en === 1'b1 && o_asleep === 1'b0, "osc first");
    while (o_awake !== 1'b1 && n < 300) begin
      if (o_ctrl.dcdc_en !== 1'b1) t_dc = n + 1;
      if (o_ctrl.offset_chg !== 1'b1 && o_ctrl.scan_en !== 1'b1) t_off = n + 1;
      if (o_ctrl.scan_en !== 1'b1) t_scan = n + 1;
      if (o_ctrl.blank === 1'b1) n_blank++;
      ld |= (o_ctrl.load_defaults === 1'b1 && n < 40);
      sd |= (o_ctrl.self_diag === 1'b1 && n < 40);
      n++;
      @(negedge i_clk);
    end
    check(t_dc < t_off && t_off < t_scan, "wake order");
    check(n_blank >= 2 * FRM && o_ctrl.blank === 1'b0, "blank");
    check(ld && sd, "defaults and diagnostics");
    check(n <= SLP && o_show_memory === 1'b1, "awake in time");
    repeat (40) @(negedge i_clk); // Let diagnostics finish first
    snap = o_ctrl;
    tx(sdmc_pkg::CMD_EXIT_SLEEP);
    repeat (3) @(negedge i_clk);
    check(o_ctrl === snap && o_awake === 1'b1, "wake ignored");
    $display("test wake done");
  endtask : t_wake
  // All-black entry and exit, idle display
  task automatic t_modes;
    snap = o_ctrl;
    tx(sdmc_pkg::CMD_ALL_BLACK);
    check(o_all_black === 1'b1 && o_show_memory === 1'b0, "black");
    check(o_ctrl === snap, "black keeps power");
    tx(sdmc_pkg::CMD_ALL_BLACK);
    check(o_all_black === 1'b1, "black again");
    tx(sdmc_pkg::CMD_NORMAL);
    check(o_all_black === 1'b0 && o_show_memory === 1'b1, "normal");
    tx(sdmc_pkg::CMD_ALL_BLACK);
    tx(sdmc_pkg::CMD_ALL_ON);
    check(o_all_black === 1'b0, "all on leaves black");
    i_idle_mode = 1'b1;
    check(o_show_memory === 1'b0, "all on hides memory");
    tx(sdmc_pkg::CMD_NORMAL);
    check(o_show_memory === 1'b1 && o_normal === 1'b1, "idle");
    $display("test modes done");
  endtask : t_modes
  // Sleep entry, then a repeated sleep
  task automatic t_sleep;
    int n = 0;
    tx(sdmc_pkg::CMD_ENTER_SLEEP);
    check(o_awake === 1'b0 && o_ctrl.backlight_en === 1'b0, "down");
    check(o_ctrl.ambient_en === 1'b0 && o_ctrl.dimming_en === 1'b0, "dim");
    while (o_asleep !== 1'b1 && n < SLP + 5) begin
      n++;
      @(negedge i_clk);
    end
    check(n <= SLP && o_ctrl === '0, "asleep in time");
    tx(sdmc_pkg::CMD_ENTER_SLEEP);
    repeat (3) @(negedge i_clk);
    check(o_asleep === 1'b1 && o_ctrl === '0, "sleep ignored");
    $display("test sleep done");
  endtask : t_sleep
  // Software reset from awake with black mode set
  task automatic t_swreset;
    tx(sdmc_pkg::CMD_ALL_BLACK);
    tx(sdmc_pkg::CMD_SW_RESET);
    repeat (2) @(negedge i_clk);
    check(o_asleep === 1'b1 && o_awake === 1'b0, "reset sleeps");
    check(o_normal === 1'b1 && o_all_black === 1'b0, "defaults");
    $display("test swreset done");
  endtask : t_swreset
  // Print counts and verdict, end the run
  task automatic stop_test;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  // Main sequence
  initial begin
    repeat (12) @(negedge i_clk);
    i_rst_b = 1'b1;
    t_reset();
    t_wake();
    t_modes();
    t_sleep();
    t_wake();
    t_swreset();
    stop_test();
  end
  // Watchdog, about sixteen times the expected run
  initial begin
    repeat (20000) @(posedge i_clk);
    n_errors++;
    stop_test();
  end
endmodule : sdmc_ctrl_bench

// File: sdmc_host.sv
// Purpose: Host model sending one-cycle command strobes
// Assumes: Strobes change on the falling clock edge
// Notes: Keeps the settling gap after power commands
`timescale 1ns/1ns
module sdmc_host #(
  parameter int GAP_CYC = 200 // Gap after a power command
) (
  input wire logic i_clk,   // Device clock
  output logic o_cmd_valid, // Command strobe
  output logic [7:0] o_cmd  // Command code
);
  int cyc = 0;        // Free cycle count
  int last = -100000; // Cycle of last power command
  // Count cycles for the spacing
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
  end
  // Idle strobe at time zero
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd = 8'h5a;
  end
  // Send one command, holding off after sleep, wake or reset
  task automatic send(input logic [7:0] code);
    while (cyc - last < GAP_CYC) @(negedge i_clk);
    @(negedge i_clk);
    o_cmd_valid = 1'b1;
    o_cmd = code;
    @(negedge i_clk);
    o_cmd_valid = 1'b0;
    o_cmd = ~code; // Stale code never lingers
    if (code == 8'h10 || code == 8'h11 || code == 8'h01) last = cyc;
  endtask : send
endmodule : sdmc_host

// File: sdmc_pkg.sv
// Purpose: Constants and types for the sleep and display mode controller
// Assumes: 100 MHz clock, commands arrive as decoded one-cycle strobes
// Notes: Timing counts are derived from the printed times
// What this block does
// - Enter sleep stops converter, oscillator, scanning
// - Command port and memory stay alive asleep
// - Sleep turns off light control, backlight, output
// - Enter sleep while asleep is ignored
// - Only exit sleep leaves sleep
// - Sleep entry completes within 120 ms
// - Exit sleep starts converter, oscillator, scanning
// - Exit sleep while awake changes no state
// - Awake leaves only by sleep or reset
// - Factory defaults reload within 5 ms wake
// - Equal defaults reload without visible disturbance
// - Self-diagnostics run within 5 ms wake
// - Fully awake within 120 ms of wake
// - Wake order oscillator, converter, offset, 2 blank
// - Normal display command restores normal mode
// - All black command blanks panel, sets status, only while awake
// - All black alters no memory or power state
// - Leave black only by all-on, normal or reset
// - Idle awake shows memory after normal command
package sdmc_pkg;

  // Command codes
  localparam logic [7:0] CMD_SW_RESET = 8'h01;
  localparam logic [7:0] CMD_ENTER_SLEEP = 8'h10;
  localparam logic [7:0] CMD_EXIT_SLEEP = 8'h11;
  localparam logic [7:0] CMD_NORMAL = 8'h13;
  localparam logic [7:0] CMD_ALL_BLACK = 8'h22;
  localparam logic [7:0] CMD_ALL_ON = 8'h23;

  // Printed times and clock rate
  localparam int CLK_HZ = 100_000_000;
  localparam int SETTLE_MS = 5;
  localparam int SLEEP_MS = 120;
  localparam int SETTLE_CYC = SETTLE_MS * (CLK_HZ / 1000);
  localparam int SLEEP_CYC = SLEEP_MS * (CLK_HZ / 1000);
  localparam int BLANK_FRAMES = 2;

  // Sequencer states
  typedef enum logic [2:0] {
    SDMC_ASLEEP,
    SDMC_OSC_UP,
    SDMC_DCDC_UP,
    SDMC_OFFSET,
    SDMC_BLANK,
    SDMC_AWAKE,
    SDMC_GOING_DOWN
  } sdmc_state_e;

  // Power and display control outputs
  typedef struct packed {
    logic osc_en;
    logic dcdc_en;
    logic scan_en;
    logic offset_chg;
    logic blank;
    logic backlight_en;
    logic ambient_en;
    logic dimming_en;
    logic load_defaults;
    logic self_diag;
  } sdmc_ctrl_s;

  // Whole module state
  typedef struct packed {
    sdmc_state_e state;
    logic [31:0] cnt;
    logic [31:0] wake_cnt;
    logic [3:0] frames;
    logic all_black;
    logic all_on;
    logic normal;
    logic asleep;
    logic awake;
    sdmc_ctrl_s ctrl;
  } sdmc_regs_s;

endpackage : sdmc_pkg
